// File: pkg/acal_pkg.sv
// acal_pkg: register map, field layout, reset values, timing counts and decoders
// assumes a 1 MHz oscillator tick and a 32-bit apb register bus
package acal_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam int unsigned ACAL_AW         = 8;
	localparam logic [7:0]  ACAL_OFF_CONFIG = 8'h00;
	localparam logic [7:0]  ACAL_OFF_RESULT = 8'h04;
	localparam logic [7:0]  ACAL_OFF_UPPER  = 8'h08;
	localparam logic [7:0]  ACAL_OFF_LOWER  = 8'h0C;
	localparam logic [7:0]  ACAL_OFF_STATUS = 8'h10;
	localparam logic [7:0]  ACAL_OFF_SCALE  = 8'h14;

	// ==========================================================
	// config field positions
	localparam int unsigned CFG_TRIG_BIT  = 15;
	localparam int unsigned CFG_GAIN_LSB  = 9;
	localparam int unsigned CFG_MODE_BIT  = 8;
	localparam int unsigned CFG_RATE_LSB  = 5;
	localparam int unsigned CFG_CMODE_BIT = 4;
	localparam int unsigned CFG_POL_BIT   = 3;
	localparam int unsigned CFG_LAT_BIT   = 2;
	localparam int unsigned CFG_QUE_LSB   = 0;

	// status and scale field positions
	localparam int unsigned STS_BUSY_BIT  = 0;
	localparam int unsigned STS_FLAG_BIT  = 1;
	localparam int unsigned STS_ARA_BIT   = 2;
	localparam int unsigned STS_PIN_BIT   = 3;
	localparam int unsigned STS_RDY_BIT   = 4;
	localparam int unsigned SCALE_FSR_LSB = 16;

	// ==========================================================
	// reset values
	localparam logic [2:0]  GAIN_RST    = 3'h2;
	localparam logic        MODE_RST    = 1'h1;
	localparam logic [2:0]  RATE_RST    = 3'h4;
	localparam logic        CMODE_RST   = 1'h0;
	localparam logic        POL_RST     = 1'h0;
	localparam logic        LAT_RST     = 1'h0;
	localparam logic [1:0]  QUE_RST     = 2'h3;
	localparam logic [1:0]  QUE_DISABLE = 2'h3;
	localparam logic [11:0] UPPER_RST   = 12'h7FF;
	localparam logic [11:0] LOWER_RST   = 12'h800;
	localparam logic [2:0]  GAIN_FIXED  = 3'h2;

	// ==========================================================
	// timing, counted in oscillator ticks
	localparam int unsigned OSC_FREQ_HZ   = 1000000;
	localparam int unsigned WAKE_TIME_US  = 25;
	localparam int unsigned RDY_PULSE_US  = 8;
	localparam int unsigned WAKE_TICKS    = WAKE_TIME_US * (OSC_FREQ_HZ / 1000000);
	localparam int unsigned RDY_TICKS     = RDY_PULSE_US * (OSC_FREQ_HZ / 1000000);
	localparam int unsigned CODE_STEPS    = 4096;
	localparam int unsigned SPS_0 = 128;
	localparam int unsigned SPS_1 = 250;
	localparam int unsigned SPS_2 = 490;
	localparam int unsigned SPS_3 = 920;
	localparam int unsigned SPS_4 = 1600;
	localparam int unsigned SPS_5 = 2400;
	localparam int unsigned SPS_6 = 3300;

	typedef enum logic [1:0] {ST_OFF, ST_WAKE, ST_CONV} acal_conv_e;

	// ==========================================================
	// decoders
	function automatic logic [15:0] acal_fsr_mv(input logic [2:0] g);
		unique case (g)
			3'h0:    acal_fsr_mv = 16'h1800;
			3'h1:    acal_fsr_mv = 16'h1000;
			3'h2:    acal_fsr_mv = 16'h0800;
			3'h3:    acal_fsr_mv = 16'h0400;
			3'h4:    acal_fsr_mv = 16'h0200;
			default: acal_fsr_mv = 16'h0100;
		endcase
	endfunction

	function automatic logic [15:0] acal_lsb_uv(input logic [2:0] g);
		logic [31:0] t;
		t = (32'(acal_fsr_mv(g)) * 32'd2000) / 32'(CODE_STEPS);
		acal_lsb_uv = t[15:0];
	endfunction

	function automatic logic [12:0] acal_rate_ticks(input logic [2:0] r);
		int unsigned t;
		unique case (r)
			3'h0:    t = OSC_FREQ_HZ / SPS_0;
			3'h1:    t = OSC_FREQ_HZ / SPS_1;
			3'h2:    t = OSC_FREQ_HZ / SPS_2;
			3'h3:    t = OSC_FREQ_HZ / SPS_3;
			3'h4:    t = OSC_FREQ_HZ / SPS_4;
			3'h5:    t = OSC_FREQ_HZ / SPS_5;
			default: t = OSC_FREQ_HZ / SPS_6;
		endcase
		acal_rate_ticks = 13'(t);
	endfunction

	function automatic logic [2:0] acal_queue_need(input logic [1:0] q);
		unique case (q)
			2'h0:    acal_queue_need = 3'h1;
			2'h1:    acal_queue_need = 3'h2;
			default: acal_queue_need = 3'h4;
		endcase
	endfunction

endpackage

// File: hw/acal_tick_sync.sv
// acal_tick_sync: two-flop synchroniser with rising-edge tick
// assumes an asynchronous input and the block clock
`timescale 1ns/1ps

module acal_tick_sync
(
	// clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// asynchronous input
	input  wire logic async_in,
	// synchronised outputs
	output logic      level,
	output logic      rise
);

	// ==========================================================
	// state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} acal_sync_s;

	acal_sync_s sync_reg;
	acal_sync_s sync_next;

	always_comb
	begin
		sync_next    = sync_reg;
		sync_next.s1 = async_in;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			sync_reg <= '0;
		else
			sync_reg <= sync_next;
	end

	assign level = sync_reg.s2;
	assign rise  = sync_reg.s2 & ~sync_reg.s3;

endmodule // acal_tick_sync

// File: hw/acal_core.sv
// acal_core: conversion sequencing, threshold comparator and alert pin control
// assumes apb master on clock, oscillator and alert line asynchronous, adc_code on clock
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

module acal_core
	import acal_pkg::*;
#(
	parameter bit          HAS_GAIN = 1'b1,
	parameter int unsigned TICK_W   = 13
)
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              arst_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ACAL_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	// oscillator and analog side
	input  wire logic              osc_in,
	input  wire logic [11:0]       adc_code,
	output logic                   adc_powered,
	output logic [2:0]             adc_gain_select,
	output logic [15:0]            full_scale_mv,
	output logic [15:0]            lsb_uv,
	// serial interface events
	input  wire logic              gc_reset,
	input  wire logic              ara_request,
	input  wire logic              ara_won,
	output logic                   ara_ack,
	output logic                   ara_status,
	// open-drain alert pin
	input  wire logic              alert_in,
	output logic                   alert_out,
	output logic                   alert_oe
);

	// ==========================================================
	// elaboration checks
	if (TICK_W < 13)
	begin : g_tick_w_check
		$error("acal_core: TICK_W too narrow for slowest rate");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [2:0]        gain_select;
		logic              single_mode;
		logic [2:0]        rate_select;
		logic              window_mode;
		logic              flag_polarity;
		logic              flag_latch_enable;
		logic [1:0]        fault_queue_count;
		logic [2:0]        act_gain;
		logic [2:0]        act_rate;
		logic [11:0]       result;
		logic [11:0]       upper_limit;
		logic [11:0]       lower_limit;
		acal_conv_e        st;
		logic [TICK_W-1:0] tick_cnt;
		logic [2:0]        q_cnt;
		logic              cmp_flag;
		logic              ara_status;
		logic              ara_ack;
		logic [3:0]        rdy_cnt;
		logic              rdy_hold;
		logic              alert_oe;
		logic [15:0]       fsr_mv;
		logic [15:0]       lsb_uv;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} acal_state_s;

	function automatic acal_state_s reset_state();
		acal_state_s s;
		s                   = '0;
		s.gain_select       = GAIN_RST;
		s.single_mode       = MODE_RST;
		s.rate_select       = RATE_RST;
		s.window_mode       = CMODE_RST;
		s.flag_polarity     = POL_RST;
		s.flag_latch_enable = LAT_RST;
		s.fault_queue_count = QUE_RST;
		s.act_gain          = GAIN_RST;
		s.act_rate          = RATE_RST;
		s.upper_limit       = UPPER_RST;
		s.lower_limit       = LOWER_RST;
		s.st                = ST_OFF;
		s.fsr_mv            = acal_fsr_mv(GAIN_RST);
		s.lsb_uv            = acal_lsb_uv(GAIN_RST);
		return s;
	endfunction

	function automatic logic [2:0] eff_gain(input logic [2:0] g);
		eff_gain = HAS_GAIN ? g : GAIN_FIXED;
	endfunction

	acal_state_s st_reg;
	acal_state_s st_next;

	logic osc_tick;
	logic alert_level;

	// ==========================================================
	// synchronisers
	acal_tick_sync u_osc_sync
	(
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in (osc_in),
		.level    (),
		.rise     (osc_tick)
	);

	acal_tick_sync u_alert_sync
	(
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in (alert_in),
		.level    (alert_level),
		.rise     ()
	);

	// ==========================================================
	// next state
	always_comb
	begin
		logic        setup;
		logic        access;
		logic        mapped;
		logic        wr_cfg;
		logic        rd_res;
		logic        rdy_mode;
		logic        done;
		logic        above;
		logic        below;
		logic        beyond;
		logic        active;
		logic [2:0]  q_inc;
		logic [31:0] rd_word;

		st_next  = st_reg;
		setup    = psel & ~penable;
		access   = psel & penable & st_reg.pready & ~st_reg.pslverr;
		mapped   = (paddr == ACAL_OFF_CONFIG) || (paddr == ACAL_OFF_RESULT) || (paddr == ACAL_OFF_UPPER) ||
		           (paddr == ACAL_OFF_LOWER) || (paddr == ACAL_OFF_STATUS) || (paddr == ACAL_OFF_SCALE);
		wr_cfg   = access & pwrite & (paddr == ACAL_OFF_CONFIG);
		rd_res   = access & ~pwrite & (paddr == ACAL_OFF_RESULT);
		rdy_mode = st_reg.upper_limit[11] & ~st_reg.lower_limit[11] &
		           (st_reg.fault_queue_count != QUE_DISABLE);
		done     = 1'b0;
		above    = $signed(adc_code) > $signed(st_reg.upper_limit);
		below    = $signed(adc_code) < $signed(st_reg.lower_limit);
		beyond   = st_reg.window_mode ? (above | below) : above;
		q_inc    = (st_reg.q_cnt == 3'h7) ? st_reg.q_cnt : st_reg.q_cnt + 3'h1;
		active   = 1'b0;

		// read mux
		rd_word = 32'h0000_0000;
		unique case (paddr)
			ACAL_OFF_CONFIG:
			begin
				rd_word[CFG_TRIG_BIT]                = (st_reg.st == ST_OFF);
				rd_word[CFG_GAIN_LSB +: 3]           = st_reg.gain_select;
				rd_word[CFG_MODE_BIT]                = st_reg.single_mode;
				rd_word[CFG_RATE_LSB +: 3]           = st_reg.rate_select;
				rd_word[CFG_CMODE_BIT]               = st_reg.window_mode;
				rd_word[CFG_POL_BIT]                 = st_reg.flag_polarity;
				rd_word[CFG_LAT_BIT]                 = st_reg.flag_latch_enable;
				rd_word[CFG_QUE_LSB +: 2]            = st_reg.fault_queue_count;
			end
			ACAL_OFF_RESULT: rd_word[11:0] = st_reg.result;
			ACAL_OFF_UPPER:  rd_word[11:0] = st_reg.upper_limit;
			ACAL_OFF_LOWER:  rd_word[11:0] = st_reg.lower_limit;
			ACAL_OFF_STATUS:
			begin
				rd_word[STS_BUSY_BIT] = (st_reg.st != ST_OFF);
				rd_word[STS_FLAG_BIT] = st_reg.cmp_flag;
				rd_word[STS_ARA_BIT]  = st_reg.ara_status;
				rd_word[STS_PIN_BIT]  = alert_level;
				rd_word[STS_RDY_BIT]  = rdy_mode;
			end
			ACAL_OFF_SCALE:  rd_word = {st_reg.fsr_mv, st_reg.lsb_uv};
			default:         rd_word = 32'h0000_0000;
		endcase

		// apb answer one cycle after setup
		st_next.pready  = setup;
		st_next.pslverr = setup & ~mapped;
		if (setup)
			st_next.prdata = rd_word;

		// register writes
		if (access & pwrite)
		begin
			unique case (paddr)
				ACAL_OFF_CONFIG:
				begin
					st_next.gain_select       = pwdata[CFG_GAIN_LSB +: 3];
					st_next.single_mode       = pwdata[CFG_MODE_BIT];
					st_next.rate_select       = pwdata[CFG_RATE_LSB +: 3];
					st_next.window_mode       = pwdata[CFG_CMODE_BIT];
					st_next.flag_polarity     = pwdata[CFG_POL_BIT];
					st_next.flag_latch_enable = pwdata[CFG_LAT_BIT];
					st_next.fault_queue_count = pwdata[CFG_QUE_LSB +: 2];
				end
				ACAL_OFF_UPPER: st_next.upper_limit = pwdata[11:0];
				ACAL_OFF_LOWER: st_next.lower_limit = pwdata[11:0];
				default:        st_next.result      = st_reg.result;
			endcase
		end

		// ======================================================
		// conversion sequencer
		unique case (st_reg.st)
			ST_OFF:
			begin
				if (wr_cfg & pwdata[CFG_TRIG_BIT] & pwdata[CFG_MODE_BIT])
				begin
					st_next.st       = ST_WAKE;
					st_next.tick_cnt = '0;
					st_next.rdy_hold = 1'b0;
				end
				else if (!st_reg.single_mode)
				begin
					st_next.st       = ST_CONV;
					st_next.tick_cnt = '0;
					st_next.rdy_hold = 1'b0;
					st_next.act_gain = eff_gain(st_reg.gain_select);
					st_next.act_rate = st_reg.rate_select;
				end
			end
			ST_WAKE:
			begin
				if (osc_tick)
				begin
					if (st_reg.tick_cnt == TICK_W'(WAKE_TICKS - 1))
					begin
						st_next.st       = ST_CONV;
						st_next.tick_cnt = '0;
						st_next.act_gain = eff_gain(st_reg.gain_select);
						st_next.act_rate = st_reg.rate_select;
					end
					else
						st_next.tick_cnt = st_reg.tick_cnt + TICK_W'(1);
				end
			end
			ST_CONV:
			begin
				if (osc_tick)
				begin
					if (st_reg.tick_cnt == TICK_W'(acal_rate_ticks(st_reg.act_rate) - 13'h1))
					begin
						done             = 1'b1;
						st_next.result   = adc_code;
						st_next.tick_cnt = '0;
						if (st_reg.single_mode)
							st_next.st = ST_OFF;
						else
						begin
							st_next.act_gain = eff_gain(st_reg.gain_select);
							st_next.act_rate = st_reg.rate_select;
						end
					end
					else
						st_next.tick_cnt = st_reg.tick_cnt + TICK_W'(1);
				end
			end
		endcase

		st_next.fsr_mv = acal_fsr_mv(st_next.act_gain);
		st_next.lsb_uv = acal_lsb_uv(st_next.act_gain);

		// ======================================================
		// comparator: clears first, so a new crossing wins
		st_next.ara_ack = ara_request & st_reg.cmp_flag & ~rdy_mode;
		if (st_reg.flag_latch_enable)
		begin
			if (rd_res)
				st_next.cmp_flag = 1'b0;
			if (ara_request & st_reg.cmp_flag & ara_won)
				st_next.cmp_flag = 1'b0;
		end

		if (done)
		begin
			st_next.q_cnt = beyond ? q_inc : 3'h0;
			if (!st_reg.flag_latch_enable)
			begin
				if (st_reg.window_mode ? (~above & ~below) : below)
					st_next.cmp_flag = 1'b0;
			end
			if (beyond & (q_inc >= acal_queue_need(st_reg.fault_queue_count)))
			begin
				st_next.cmp_flag   = 1'b1;
				st_next.ara_status = above;
			end
			if (!st_reg.single_mode)
				st_next.rdy_cnt = 4'(RDY_TICKS);
			else
				st_next.rdy_hold = 1'b1;
		end
		else if (osc_tick && (st_reg.rdy_cnt != 4'h0))
			st_next.rdy_cnt = st_reg.rdy_cnt - 4'h1;

		if (st_reg.fault_queue_count == QUE_DISABLE)
		begin
			st_next.cmp_flag = 1'b0;
			st_next.q_cnt    = 3'h0;
		end

		// ======================================================
		// general-call reset
		if (gc_reset)
		begin
			st_next         = reset_state();
			st_next.pready  = setup;
			st_next.pslverr = setup & ~mapped;
			st_next.prdata  = setup ? rd_word : st_reg.prdata;
		end

		// ======================================================
		// pin drive from next state
		rdy_mode = st_next.upper_limit[11] & ~st_next.lower_limit[11] &
		           (st_next.fault_queue_count != QUE_DISABLE);
		active   = rdy_mode ? ((st_next.rdy_cnt != 4'h0) | st_next.rdy_hold) : st_next.cmp_flag;
		if (st_next.fault_queue_count == QUE_DISABLE)
			st_next.alert_oe = 1'b0;
		else
			st_next.alert_oe = st_next.flag_polarity ? ~active : active;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st_reg <= reset_state();
		else
			st_reg <= st_next;
	end

	// ==========================================================
	// outputs
	assign pready          = st_reg.pready;
	assign pslverr         = st_reg.pslverr;
	assign prdata          = st_reg.prdata;
	assign adc_powered     = (st_reg.st != ST_OFF);
	assign adc_gain_select = st_reg.act_gain;
	assign full_scale_mv   = st_reg.fsr_mv;
	assign lsb_uv          = st_reg.lsb_uv;
	assign ara_ack         = st_reg.ara_ack;
	assign ara_status      = st_reg.ara_status;
	assign alert_out       = 1'b0;
	assign alert_oe        = st_reg.alert_oe;

endmodule // acal_core

// File: tb/acal_core_properties.sv
// acal_core_properties: port-level assertions for acal_core
// assumes oscillator far slower than clock, bound into every acal_core
`timescale 1ns/1ps

module acal_core_properties
(
	// clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// converter side
	input wire logic        osc_in,
	input wire logic        adc_powered,
	input wire logic [15:0] full_scale_mv,
	input wire logic [15:0] lsb_uv,
	// events and pin
	input wire logic        gc_reset,
	input wire logic        ara_request,
	input wire logic        ara_won,
	input wire logic        ara_ack,
	input wire logic        alert_out,
	input wire logic        alert_oe
);
	// ==========================================
	// oscillator ticks seen while powered
	logic [2:0]  osc_s;
	logic [15:0] tk;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			osc_s <= 3'h0;
			tk    <= 16'h0;
		end
		else
		begin
			osc_s <= {osc_s[1:0], osc_in};
			if (!adc_powered)
				tk <= 16'h0;
			else if (osc_s[1] && !osc_s[2])
				tk <= tk + 16'h1;
		end
	end

	// ==========================================
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	sequence s_lose;
		ara_request && !ara_won;
	endsequence
	sequence s_hold;
		$stable(alert_oe) [*3];
	endsequence

	a_fsr_legal: assert property (
		full_scale_mv inside {16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100})
		else $error("full scale outside the six ranges");
	a_lsb_ratio: assert property (lsb_uv == 16'((32'(full_scale_mv) * 32'h7D0) / 32'h1000))
		else $error("step size not full scale over 4096");
	a_gc_powerdown: assert property (gc_reset |-> ##[1:3] !adc_powered)
		else $error("still powered after general reset");
	a_gc_release: assert property (gc_reset |-> ##[1:3] !alert_oe)
		else $error("pin pulled after general reset");
	a_od_low_only: assert property (alert_out == 1'b0)
		else $error("pin driven high");
	a_ack_cause: assert property (ara_ack |-> $past(ara_request))
		else $error("alert answer without command");
	a_conv_span: assert property (
		$fell(adc_powered) && !$past(gc_reset) && !$past(gc_reset, 2) |-> tk >= 16'h140)
		else $error("wake plus conversion too short");
	a_loser_keeps: assert property (s_lose |=> s_hold)
		else $error("losing device changed its pin");
endmodule // acal_core_properties

bind acal_core acal_core_properties u_props (.clock(clock), .arst_n(arst_n), .osc_in(osc_in),
	.adc_powered(adc_powered), .full_scale_mv(full_scale_mv), .lsb_uv(lsb_uv), .gc_reset(gc_reset),
	.ara_request(ara_request), .ara_won(ara_won), .ara_ack(ara_ack), .alert_out(alert_out), .alert_oe(alert_oe));

// File: tb/acal_host_model.sv
// acal_host_model: bus controller events and pulled-up alert line
// assumes tasks are called from the bench on the block clock
`timescale 1ns/1ps

module acal_host_model
#(
	parameter logic [6:0] OWN_ADDR   = 7'h2A,
	parameter logic [6:0] OTHER_ADDR = 7'h21
)
(
	// clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// pin side
	input  wire logic alert_out,
	input  wire logic alert_oe,
	input  wire logic ara_ack,
	output logic      alert_in,
	// command events
	output logic      gc_reset,
	output logic      ara_request,
	output logic      ara_won
);
	// ==========================================
	assign alert_in = alert_oe ? alert_out : 1'b1;

	initial
	begin
		gc_reset    = 1'b0;
		ara_request = 1'b0;
		ara_won     = 1'b0;
	end

	// alert command; a rival device may also answer
	task automatic alert_response(input bit rival, output logic ack);
		@(posedge clock);
		ara_request <= 1'b1;
		ara_won     <= !(rival && OTHER_ADDR < OWN_ADDR);
		@(posedge clock);
		ara_request <= 1'b0;
		ara_won     <= 1'b0;
		@(posedge clock);
		ack = ara_ack;
	endtask

	task automatic general_reset();
		@(posedge clock);
		gc_reset <= 1'b1;
		@(posedge clock);
		gc_reset <= 1'b0;
	endtask
endmodule // acal_host_model

// File: tb/test_adc_conversion_and_alert_logic.sv
// test_adc_conversion_and_alert_logic: self-checking bench for acal_core
// assumes acal_core, host model and bound checker compiled before
`timescale 1ns/1ps

module test_adc_conversion_and_alert_logic import acal_pkg::*;;
	// ==========================================
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        osc_in = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, cur;
	logic [11:0] adc_code = 12'h000;
	logic [15:0] full_scale_range, lsb;
	logic [2:0]  gsel;
	logic        pready, pslverr, adc_powered, gc_reset, ara_request, ara_won, ara_ack, ara_status;
	logic        alert_in, alert_out, alert_oe, er, ack;
	logic [15:0] fsr_tab [7] = '{16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0100};
	logic [11:0] codes [$];
	time         tk0;
	int          err_total = 0, num_checks = 0, seed = 75, wn, m_up, m_lo, m_cnt, m_need;
	bit          m_flag, m_win, m_lat, m_pol, m_hi;

	always #25 clock = ~clock;
	initial
	begin
		#37;
		forever #200 osc_in = ~osc_in;
	end

	acal_core #(.HAS_GAIN(1'b1), .TICK_W(13)) u_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .osc_in(osc_in), .adc_code(adc_code), .adc_powered(adc_powered), .adc_gain_select(gsel),
		.full_scale_mv(full_scale_range), .lsb_uv(lsb), .gc_reset(gc_reset), .ara_request(ara_request), .ara_won(ara_won),
		.ara_ack(ara_ack), .ara_status(ara_status), .alert_in(alert_in), .alert_out(alert_out), .alert_oe(alert_oe));
	acal_host_model u_host (.clock(clock), .arst_n(arst_n), .alert_out(alert_out), .alert_oe(alert_oe),
		.ara_ack(ara_ack), .alert_in(alert_in), .gc_reset(gc_reset), .ara_request(ara_request), .ara_won(ara_won));

	// ==========================================
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_on(input bit pin, input logic v, input int lim);
		wn = 0;
		while ((pin ? alert_oe : adc_powered) !== v && wn < lim)
		begin
			@(posedge clock);
			wn++;
		end
		chk("wait_level", 32'(v), 32'(pin ? alert_oe : adc_powered));
	endtask

	// reference comparator, one step per finished conversion
	function automatic void m_step(input int c);
		bit hi, lo;
		hi = c > m_up;
		lo = c < m_lo;
		if (m_need == 0)
		begin
			m_cnt = 0;
			return;
		end
		m_cnt = (hi || (m_win && lo)) ? m_cnt + 1 : 0;
		if (m_cnt >= m_need)
		begin
			m_flag = 1'b1;
			m_hi   = hi;
		end
		else if (!m_lat && (m_win ? !(hi || lo) : lo))
			m_flag = 1'b0;
	endfunction

	task automatic setcfg(input logic [2:0] g, input logic [2:0] cm, input logic [1:0] q);
		cur = 32'(g) << CFG_GAIN_LSB | 32'h1 << CFG_MODE_BIT | 32'h6 << CFG_RATE_LSB | 32'(cm) << CFG_LAT_BIT | 32'(q);
		{m_win, m_pol, m_lat} = cm;
		m_need = (q == 2'h3) ? 0 : (q == 2'h2) ? 4 : int'(q) + 1;
		apb(1'b1, ACAL_OFF_CONFIG, cur);
	endtask

	task automatic conv(input logic [11:0] code, input bit rdres, input bit poke);
		adc_code <= code;
		apb(1'b1, ACAL_OFF_CONFIG, cur | 32'h8000);
		wait_on(1'b0, 1'b1, 100);
		tk0 = $time;
		if (poke)
			apb(1'b1, ACAL_OFF_CONFIG, cur | 32'h8000);
		wait_on(1'b0, 1'b0, 4000);
		chk("conv_len", 32'h1, 32'(($time - tk0) / 50 > 2570 && ($time - tk0) / 50 < 2680));
		m_step(int'($signed(code)));
		repeat (4) @(posedge clock);
		chk("alert_oe", 32'(m_need > 0 && (m_flag ^ m_pol)), 32'(alert_oe));
		if (m_win && m_flag)
			chk("ara_status", 32'(m_hi), 32'(ara_status));
		if (rdres)
		begin
			apb(1'b0, ACAL_OFF_RESULT, 32'h0);
			chk("result", 32'(code), rd);
			m_flag = m_flag && !m_lat;
			repeat (2) @(posedge clock);
			chk("oe_after_read", 32'(m_need > 0 && (m_flag ^ m_pol)), 32'(alert_oe));
		end
	endtask

	// ==========================================
	initial
	begin
		#4500000;
		err_total++;
		give_verdict();
	end

	initial
	begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		apb(1'b0, ACAL_OFF_CONFIG, 32'h0);
		chk("cfg_rst", 32'h0000_8583, rd);
		apb(1'b0, ACAL_OFF_SCALE, 32'h0);
		chk("scale_rst", 32'h0800_03E8, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("bad_addr", 32'h1, 32'(er));
		for (int g = 0; g < 7; g++)
		begin
			setcfg(3'(g), 3'h0, 2'h3);
			conv(12'($random(seed)), 1'b1, g == 3);
			chk("gain_sel", 32'(g), 32'(gsel));
			apb(1'b0, ACAL_OFF_SCALE, 32'h0);
			chk("scale", {fsr_tab[g], 16'(32'(fsr_tab[g]) * 32'h7D0 / 32'h1000)}, rd);
		end
		apb(1'b1, ACAL_OFF_UPPER, 32'h100);
		apb(1'b1, ACAL_OFF_LOWER, 32'hF00);
		m_up = 256;
		m_lo = -256;
		setcfg(3'h2, 3'h5, 2'h0);
		conv(12'h200, 1'b0, 1'b0);
		u_host.alert_response(1'b1, ack);
		chk("ack_lose", 32'h1, 32'(ack));
		chk("oe_lose", 32'h1, 32'(alert_oe));
		u_host.alert_response(1'b0, ack);
		m_flag = 1'b0;
		repeat (2) @(posedge clock);
		chk("oe_win", 32'h0, 32'(alert_oe));
		conv(12'h000, 1'b0, 1'b0);
		conv(12'hE00, 1'b0, 1'b0);
		conv(12'h000, 1'b1, 1'b0);
		setcfg(3'h2, 3'h7, 2'h0);
		repeat (3) @(posedge clock);
		chk("oe_pol", 32'h1, 32'(alert_oe));
		conv(12'h200, 1'b1, 1'b0);
		setcfg(3'h2, 3'h0, 2'h2);
		codes = '{12'h200, 12'h200, 12'h200, 12'h200, 12'h000, 12'hE00};
		foreach (codes[i])
			conv(codes[i], 1'b1, 1'b0);
		apb(1'b1, ACAL_OFF_UPPER, 32'h800);
		apb(1'b1, ACAL_OFF_LOWER, 32'h000);
		adc_code <= 12'h3A5;
		cur = 32'h2 << CFG_GAIN_LSB | 32'h6 << CFG_RATE_LSB;
		apb(1'b1, ACAL_OFF_CONFIG, cur);
		wait_on(1'b1, 1'b0, 4000);
		wait_on(1'b1, 1'b1, 4000);
		wait_on(1'b1, 1'b0, 200);
		chk("rdy_width", 32'h1, 32'(wn > 56 && wn < 72));
		wait_on(1'b1, 1'b1, 4000);
		chk("rdy_period", 32'h1, 32'(wn > 2340 && wn < 2380));
		apb(1'b0, ACAL_OFF_RESULT, 32'h0);
		chk("cont_result", 32'h3A5, rd);
		cur = cur | 32'h1 << CFG_MODE_BIT;
		apb(1'b1, ACAL_OFF_CONFIG, cur);
		wait_on(1'b0, 1'b0, 4000);
		apb(1'b1, ACAL_OFF_CONFIG, cur | 32'h8000);
		wait_on(1'b0, 1'b1, 100);
		wait_on(1'b0, 1'b0, 4000);
		repeat (4) @(posedge clock);
		chk("rdy_single", 32'h1, 32'(alert_oe));
		u_host.general_reset();
		repeat (3) @(posedge clock);
		chk("oe_gc", 32'h0, 32'(alert_oe));
		apb(1'b0, ACAL_OFF_CONFIG, 32'h0);
		chk("cfg_gc", 32'h0000_8583, rd);
		give_verdict();
	end
endmodule // test_adc_conversion_and_alert_logic
